// >>> hdl/wss_pkg.sv
// Constants shared by the weld stepper schedule-select logic.
// Assumes a single 250 MHz clock and schedule numbers coded in binary.
package wss_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int HOLD_TIME_MS = 500;
	localparam int HOLD_CYCLES_DEF = HOLD_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam int HOLD_W = 27;
	// ----------------------------------------
	// Widths and ranges
	// ----------------------------------------
	localparam int SCHED_W = 6;
	localparam int STP_W = 3;
	localparam int COUNT_W = 14;
	localparam int NUM_STEPPERS = 5;
	localparam int NUM_SCHEDS = 50;
	localparam logic [SCHED_W-1:0] STEPS_PER_STEPPER = 6'h0A;
	localparam logic [SCHED_W-1:0] MAX_STEP_MULTI = 6'h09;
	localparam logic [SCHED_W-1:0] MAX_SCHED = 6'h31;
	localparam logic [SCHED_W-1:0] SCHED_ZERO = 6'h00;
	localparam logic [SCHED_W-1:0] SCHED_SECOND = 6'h0A;
	localparam logic [SCHED_W-1:0] SCHED_THIRD = 6'h14;
	localparam logic [COUNT_W-1:0] MAX_COUNT = 14'h270F;
	localparam logic [COUNT_W-1:0] COUNT_ZERO = 14'h0000;
	localparam logic [COUNT_W-1:0] COUNT_ONE = 14'h0001;
	localparam logic [STP_W-1:0] STP_FIRST = 3'h0;
	localparam logic [STP_W-1:0] STP_SECOND = 3'h1;
	localparam logic [STP_W-1:0] STP_THIRD = 3'h2;
	localparam logic [STP_W-1:0] STP_FOURTH = 3'h3;
	localparam logic [STP_W-1:0] STP_FIFTH = 3'h4;
	// ----------------------------------------
	// Settings and codes
	// ----------------------------------------
	localparam logic [1:0] STEPPER_OFF = 2'h0;
	localparam logic [1:0] STEPPER_MULTI = 2'h1;
	localparam logic [1:0] STEPPER_SINGLE = 2'h2;
	localparam logic [1:0] SELECT_INTERNAL = 2'h0;
	localparam logic [1:0] SELECT_EXTERNAL = 2'h1;
	localparam logic [1:0] SELECT_BINARY = 2'h3;
	localparam logic [1:0] PLACE_UNITS = 2'h0;
	localparam logic [1:0] PLACE_TENS = 2'h1;
	localparam logic [1:0] PLACE_HUNDREDS = 2'h2;
	localparam logic [1:0] PLACE_THOUSANDS = 2'h3;
	localparam int PIN_W = 11;
	typedef enum logic [0:0] {
		WSS_IDLE = 1'b0,
		WSS_RUN = 1'b1
	} wss_state_t;
	function automatic logic [STP_W-1:0] wss_stepper_of(input logic [SCHED_W-1:0] s);
		if (s >= 6'h28) return STP_FIFTH;
		if (s >= 6'h1E) return STP_FOURTH;
		if (s >= SCHED_THIRD) return STP_THIRD;
		if (s >= SCHED_SECOND) return STP_SECOND;
		return STP_FIRST;
	endfunction
	function automatic logic [SCHED_W-1:0] wss_base_of(input logic [STP_W-1:0] k);
		return SCHED_W'(k * STEPS_PER_STEPPER);
	endfunction
endpackage

// >>> hdl/wss_stepper_select.sv
// Weld stepper counters and initiation schedule selection, with front-panel gesture decoding.
// Assumes pins arrive asynchronously and the sequencer on this clock pulses seqDone once per sequence.
// ----------------------------------------
// Pin synchroniser
// ----------------------------------------
module wss_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] level
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	wire [W-1:0] agree = ~(s2 ^ s3);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			level <= '0;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			level <= (agree & s3) | (~agree & level);
		end
	end
endmodule
// ----------------------------------------
// Short or held press classifier
// ----------------------------------------
module wss_press import wss_pkg::*; #(
	parameter int HOLD_CYCLES = HOLD_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic btn,
	input wire logic enable,
	output logic heldPulse,
	output logic shortPulse
);
	logic [HOLD_W-1:0] cnt;
	logic fired;
	wire reached = cnt == HOLD_W'(HOLD_CYCLES - 1);
	// A held press reports once at the hold mark; the release then reports nothing.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= '0;
			fired <= 1'b0;
			heldPulse <= 1'b0;
			shortPulse <= 1'b0;
		end else begin
			heldPulse <= enable && btn && !fired && reached;
			shortPulse <= enable && !btn && !fired && cnt != '0;
			fired <= btn && (fired || reached);
			cnt <= (btn && !reached) ? cnt + HOLD_W'(1) : (btn ? cnt : '0);
		end
	end
endmodule
// Operation
// [RL1] Last step accepted 00-09 in multi mode, 00-49 in single mode.
// [RL2] Last step is the starting step; stepper reset overwrites it.
// [RL3] Last count 0000-9999 is the starting count of the sequence.
// [RL4] With all steps used, stop starting and flag end of stepper.
// [RL5] Steppers one to five start at schedules 00, 10, 20, 30, 40.
// [RL6] Internal select: primary input starts the stepper owning the dialed schedule.
// [RL7] Internal select: second input always starts the second stepper.
// [RL8] Internal select: third input always starts the third stepper.
// [RL9] External select: second and third inputs pick one of four steppers.
// [RL10] Binary select: no weight selects first; one weight selects second to fifth.
// [RL11] Single-counter mode decrements only on primary initiation.
// [RL12] Single-counter: second or third input runs schedule 10 or 20, no decrement.
// [RL13] Single-counter with binary select: second input runs the selected schedule.
// [RL14] Count entry: held/short left gives thousands/hundreds, right gives tens/units.
// [RL15] Program mode: enter held plus right schedule button copies the schedule.
// [RL16] Program mode: enter held plus both data buttons resets the dialed stepper.
// [RL17] Decrement only for a real weld: time, current programmed and weld mode.
// [RL18] Stepper setting: 00 off, 01 five steppers of ten steps, 02 single counter.
// [RL19] Each step weld count is programmable 0000-9999.
// [RL20] At zero count, advance step and load that step's programmed count.
module wss_stepper_select import wss_pkg::*; #(
	parameter int HOLD_CYCLES = HOLD_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [1:0] stepperMode,
	input wire logic [1:0] scheduleSelect,
	input wire logic programMode,
	input wire logic countEntry,
	input wire logic [SCHED_W-1:0] dialedSched,
	input wire logic primary_initiation_input,
	input wire logic second_initiation_input,
	input wire logic third_initiation_input,
	input wire logic select_weight_one,
	input wire logic select_weight_two,
	input wire logic select_weight_four,
	input wire logic select_weight_eight,
	input wire logic enterBtn,
	input wire logic leftDataBtn,
	input wire logic rightDataBtn,
	input wire logic rightSchedBtn,
	input wire logic weldTimeSet,
	input wire logic weldCurrentSet,
	input wire logic weldMode,
	input wire logic seqDone,
	input wire logic stepCountWrite,
	input wire logic [SCHED_W-1:0] stepCountSched,
	input wire logic [COUNT_W-1:0] stepCountData,
	input wire logic lastWrite,
	input wire logic [SCHED_W-1:0] lastWriteStep,
	input wire logic [COUNT_W-1:0] lastWriteCount,
	output logic startPulse,
	output logic [SCHED_W-1:0] startSched,
	output logic [STP_W-1:0] startStepper,
	output logic startDecrements,
	output logic runActive,
	output logic endOfStepper,
	output logic [SCHED_W-1:0] shownStep,
	output logic [COUNT_W-1:0] shownCount,
	output logic digitPulse,
	output logic [1:0] digitPlace,
	output logic copyPulse,
	output logic stepperResetPulse
);
	// ----------------------------------------
	// Inputs and edges
	// ----------------------------------------
	logic [PIN_W-1:0] pins;
	logic [PIN_W-1:0] prev;
	wss_sync #(.W(PIN_W)) uSync (
		.clk(clk),
		.resetn(resetn),
		.pin({primary_initiation_input, second_initiation_input, third_initiation_input,
			select_weight_one, select_weight_two, select_weight_four, select_weight_eight,
			enterBtn, leftDataBtn, rightDataBtn, rightSchedBtn}),
		.level(pins)
	);
	wire [PIN_W-1:0] rise = pins & ~prev;
	wire priRise = rise[10];
	wire secRise = rise[9];
	wire thrRise = rise[8];
	wire secLvl = pins[9];
	wire thrLvl = pins[8];
	wire [3:0] weights = {pins[4], pins[5], pins[6], pins[7]};
	wire enterLvl = pins[3];
	wire leftLvl = pins[2];
	wire rightLvl = pins[1];
	wire schedRightRise = rise[0];
	// ----------------------------------------
	// Stepper state
	// ----------------------------------------
	logic [COUNT_W-1:0] stepCount [NUM_SCHEDS];
	logic [SCHED_W-1:0] lastStep [NUM_STEPPERS];
	logic [COUNT_W-1:0] lastCount [NUM_STEPPERS];
	logic [NUM_STEPPERS-1:0] ended;
	wss_state_t state;
	logic [STP_W-1:0] activeStp;
	logic activeDec;
	wire single = stepperMode == STEPPER_SINGLE; // [RL18]
	wire multi = stepperMode == STEPPER_MULTI; // [RL18]
	wire [STP_W-1:0] dialStp = single ? STP_FIRST : wss_stepper_of(dialedSched);
	// ----------------------------------------
	// Initiation selection
	// ----------------------------------------
	wire extSel = scheduleSelect == SELECT_EXTERNAL;
	wire binSel = scheduleSelect == SELECT_BINARY;
	wire binOk = weights == 4'h0 || weights == 4'h1 || weights == 4'h2 || weights == 4'h4 || weights == 4'h8; // [RL10]
	wire [STP_W-1:0] binStp = weights[3] ? STP_FIFTH : weights[2] ? STP_FOURTH :
		weights[1] ? STP_THIRD : weights[0] ? STP_SECOND : STP_FIRST; // [RL10]
	wire [STP_W-1:0] extStp = {1'b0, thrLvl, secLvl}; // [RL9]
	wire [STP_W-1:0] priStp = extSel ? extStp : binSel ? binStp : dialStp; // [RL6]
	wire priOk = binSel ? binOk : (extSel || dialedSched <= MAX_SCHED);
	wire internalStart = !extSel && !binSel && (secRise || thrRise);
	wire [STP_W-1:0] auxStp = secRise ? STP_SECOND : STP_THIRD; // [RL7] [RL8]
	wire [SCHED_W-1:0] auxSched = (secRise && binSel && binOk) ? wss_base_of(binStp) :
		(secRise ? SCHED_SECOND : SCHED_THIRD); // [RL12] [RL13]
	logic trigOk;
	logic trigDec;
	logic [STP_W-1:0] trigStp;
	logic [SCHED_W-1:0] trigSched;
	always_comb begin
		trigOk = 1'b0;
		trigDec = 1'b0;
		trigStp = STP_FIRST;
		trigSched = dialedSched;
		if (multi) begin
			trigStp = priRise ? priStp : auxStp;
			trigSched = wss_base_of(trigStp) + lastStep[trigStp]; // [RL5] [RL2]
			trigDec = 1'b1;
			trigOk = priRise ? priOk : internalStart;
		end else if (single) begin
			trigSched = priRise ? lastStep[STP_FIRST] : auxSched; // [RL2]
			trigDec = priRise; // [RL11] [RL12]
			trigOk = priRise || secRise || thrRise;
		end else
			trigOk = priRise && dialedSched <= MAX_SCHED;
		if (trigDec && ended[trigStp])
			trigOk = 1'b0; // [RL4]
	end
	wire startNow = state == WSS_IDLE && trigOk;
	// ----------------------------------------
	// Count advance
	// ----------------------------------------
	wire weldOk = weldTimeSet && weldCurrentSet && weldMode; // [RL17]
	wire doDec = state == WSS_RUN && seqDone && activeDec && weldOk;
	wire [COUNT_W-1:0] curCnt = lastCount[activeStp];
	wire [SCHED_W-1:0] nxtStep = lastStep[activeStp] + SCHED_W'(1);
	wire stepOver = nxtStep > (single ? MAX_SCHED : MAX_STEP_MULTI);
	wire [SCHED_W-1:0] nxtSched = single ? nxtStep : wss_base_of(activeStp) + nxtStep;
	wire [COUNT_W-1:0] nxtCnt = stepOver ? COUNT_ZERO : stepCount[nxtSched];
	wire stepDone = curCnt <= COUNT_ONE; // [RL20]
	// ----------------------------------------
	// Front-panel gestures
	// ----------------------------------------
	wire resetGesture = programMode && enterLvl && leftLvl && rightLvl &&
		(rise[2] || rise[1]); // [RL16]
	wire copyGesture = programMode && enterLvl && schedRightRise; // [RL15]
	wire [SCHED_W-1:0] firstSched = single ? SCHED_ZERO : wss_base_of(dialStp);
	wire lastOk = lastWriteCount <= MAX_COUNT &&
		lastWriteStep <= (single ? MAX_SCHED : MAX_STEP_MULTI); // [RL1] [RL3]
	wire entryOn = countEntry && !enterLvl;
	logic leftHeld;
	logic leftShort;
	logic rightHeld;
	logic rightShort;
	wss_press #(.HOLD_CYCLES(HOLD_CYCLES)) uLeft (
		.clk(clk),
		.resetn(resetn),
		.btn(leftLvl),
		.enable(entryOn),
		.heldPulse(leftHeld),
		.shortPulse(leftShort)
	);
	wss_press #(.HOLD_CYCLES(HOLD_CYCLES)) uRight (
		.clk(clk),
		.resetn(resetn),
		.btn(rightLvl),
		.enable(entryOn),
		.heldPulse(rightHeld),
		.shortPulse(rightShort)
	);
	wire anyDigit = leftHeld || leftShort || rightHeld || rightShort;
	wire [1:0] placeSel = leftHeld ? PLACE_THOUSANDS : leftShort ? PLACE_HUNDREDS :
		rightHeld ? PLACE_TENS : PLACE_UNITS; // [RL14]
	// ----------------------------------------
	// Step count table
	// ----------------------------------------
	// Kept without reset so it maps onto a plain memory.
	always_ff @(posedge clk) begin
		if (stepCountWrite && stepCountSched <= MAX_SCHED && stepCountData <= MAX_COUNT)
			stepCount[stepCountSched] <= stepCountData; // [RL19]
	end
	// ----------------------------------------
	// Last step, last count and end flags
	// ----------------------------------------
	// Reset gesture wins over a manual write, which wins over a decrement.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < NUM_STEPPERS; i++) begin
				lastStep[i] <= SCHED_ZERO;
				lastCount[i] <= COUNT_ZERO;
			end
			ended <= '0;
		end else if (resetGesture && stepperMode != STEPPER_OFF) begin
			lastStep[dialStp] <= SCHED_ZERO; // [RL2] [RL16]
			lastCount[dialStp] <= stepCount[firstSched];
			ended[dialStp] <= 1'b0;
		end else if (lastWrite && lastOk && stepperMode != STEPPER_OFF) begin
			lastStep[dialStp] <= lastWriteStep; // [RL1]
			lastCount[dialStp] <= lastWriteCount; // [RL3]
			ended[dialStp] <= 1'b0;
		end else if (doDec) begin
			if (!stepDone) begin
				lastCount[activeStp] <= curCnt - COUNT_ONE;
			end else if (stepOver || nxtCnt == COUNT_ZERO) begin
				lastCount[activeStp] <= COUNT_ZERO;
				ended[activeStp] <= 1'b1; // [RL4]
			end else begin
				lastStep[activeStp] <= nxtStep; // [RL20]
				lastCount[activeStp] <= nxtCnt;
			end
		end
	end
	// ----------------------------------------
	// Sequence tracking and outputs
	// ----------------------------------------
	wire [SCHED_W-1:0] next_shownStep = single ? lastStep[STP_FIRST] : lastStep[dialStp];
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prev <= '0;
			state <= WSS_IDLE;
			activeStp <= STP_FIRST;
			activeDec <= 1'b0;
			startPulse <= 1'b0;
			startSched <= SCHED_ZERO;
			startStepper <= STP_FIRST;
			startDecrements <= 1'b0;
			runActive <= 1'b0;
			endOfStepper <= 1'b0;
			shownStep <= SCHED_ZERO;
			shownCount <= COUNT_ZERO;
			digitPulse <= 1'b0;
			digitPlace <= PLACE_UNITS;
			copyPulse <= 1'b0;
			stepperResetPulse <= 1'b0;
		end else begin
			prev <= pins;
			unique case (state)
				WSS_IDLE: begin
					if (startNow) begin
						state <= WSS_RUN;
						activeStp <= trigStp;
						activeDec <= trigDec && stepperMode != STEPPER_OFF;
						startSched <= trigSched;
						startStepper <= trigStp;
						startDecrements <= trigDec && stepperMode != STEPPER_OFF;
					end
				end
				WSS_RUN: begin
					if (seqDone)
						state <= WSS_IDLE;
				end
			endcase
			startPulse <= startNow;
			runActive <= startNow || (state == WSS_RUN && !seqDone);
			endOfStepper <= stepperMode != STEPPER_OFF && ended[dialStp]; // [RL4]
			shownStep <= next_shownStep;
			shownCount <= lastCount[dialStp];
			digitPulse <= anyDigit;
			if (anyDigit)
				digitPlace <= placeSel;
			copyPulse <= copyGesture;
			stepperResetPulse <= resetGesture && stepperMode != STEPPER_OFF;
		end
	end
endmodule

// >>> tb/wss_stepper_select_properties.sv
// Port-level checks for the stepper schedule-select block.
// Assumes one clock domain with the asynchronous active-low reset.
module wss_stepper_select_properties import wss_pkg::*; (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [1:0] stepperMode,
	input wire logic programMode,
	input wire logic weldMode,
	input wire logic seqDone,
	input wire logic lastWrite,
	input wire logic startPulse,
	input wire logic [SCHED_W-1:0] startSched,
	input wire logic [STP_W-1:0] startStepper,
	input wire logic runActive,
	input wire logic [COUNT_W-1:0] shownCount,
	input wire logic digitPulse,
	input wire logic copyPulse,
	input wire logic stepperResetPulse
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	AST_START_ONCE: assert property (startPulse |=> !startPulse) else $error("start pulse too wide");
	AST_NO_REENTRY: assert property (startPulse |-> runActive && !($past(runActive) && !$past(seqDone)))
		else $error("start while running");
	AST_RUN_ENDS: assert property (seqDone && runActive |=> !runActive || startPulse) else $error("run held");
	AST_STEPPER_BASE: assert property (startPulse && stepperMode == STEPPER_MULTI |->
		startSched / 6'h0A == {3'h0, startStepper}) else $error("schedule outside stepper");
	AST_DIGIT_ONCE: assert property (digitPulse |=> !digitPulse) else $error("digit pulse too wide");
	AST_COPY_PROG: assert property (copyPulse |-> $past(programMode)) else $error("copy outside program");
	AST_RESET_PROG: assert property (stepperResetPulse |-> $past(programMode) && stepperMode != STEPPER_OFF)
		else $error("stepper reset refused case");
	// A sequence ending with weld mode off must leave the shown count alone two edges on.
	AST_NO_WELD_HOLD: assert property (seqDone && !weldMode && !lastWrite |=> ##1 $stable(shownCount))
		else $error("count moved without weld");
	COV_START: cover property (startPulse && runActive);
	COV_COPY: cover property (copyPulse);
	COV_RESET: cover property (stepperResetPulse);
endmodule

bind wss_stepper_select wss_stepper_select_properties chk_i (.clk(clk), .resetn(resetn),
	.stepperMode(stepperMode), .programMode(programMode), .weldMode(weldMode), .seqDone(seqDone),
	.lastWrite(lastWrite), .startPulse(startPulse), .startSched(startSched), .startStepper(startStepper),
	.runActive(runActive), .shownCount(shownCount), .digitPulse(digitPulse), .copyPulse(copyPulse),
	.stepperResetPulse(stepperResetPulse));

// >>> tb/wss_panel_model.sv
// Operator panel buttons and terminal-strip switches.
// Assumes the bench calls its tasks; every change lands on a falling edge.
module wss_panel_model (
	input wire logic clk,
	output logic [2:0] init,
	output logic [3:0] weight,
	output logic [3:0] btn
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		init = 3'h0;
		weight = 4'h0;
		btn = 4'h0;
	end
	// Closures last six cycles so the three-stage synchroniser always sees them.
	task automatic tap(input int w);
		@(negedge clk) init[w] = 1'b1;
		repeat (6) @(negedge clk);
		init[w] = 1'b0;
	endtask
	task automatic press(input logic [3:0] pre, input logic [3:0] m, input int len);
		@(negedge clk) btn = pre;
		repeat (3) @(negedge clk);
		btn = pre | m;
		repeat (len) @(negedge clk);
		btn = 4'h0;
		repeat (4) @(negedge clk);
	endtask
	task automatic lvl(input logic [1:0] i, input logic [3:0] w);
		@(negedge clk);
		init[2:1] = i;
		weight = w;
		repeat (6) @(negedge clk);
	endtask
endmodule

// >>> tb/tb_wss_stepper_select.sv
// Self-checking bench for the stepper schedule-select block.
// Assumes the panel model drives pins and buttons, with the hold time cut to 8 cycles.
module tb_wss_stepper_select import wss_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, resetn = 1'b0, programMode = 1'b0, countEntry = 1'b0, weldMode = 1'b1;
	logic seqDone = 1'b0, stepCountWrite = 1'b0, lastWrite = 1'b0, weldTimeSet = 1'b1, weldCurrentSet = 1'b1;
	logic [1:0] stepperMode = 2'h1, scheduleSelect = 2'h0, digitPlace, plc;
	logic [SCHED_W-1:0] dialedSched = 6'h0C, stepCountSched = 6'h00, lastWriteStep = 6'h00;
	logic [COUNT_W-1:0] stepCountData = 14'h0000, lastWriteCount = 14'h0000, shownCount;
	logic startPulse, startDecrements, runActive, endOfStepper, digitPulse, copyPulse, stepperResetPulse;
	logic [SCHED_W-1:0] startSched, shownStep;
	logic [STP_W-1:0] startStepper;
	wire logic [2:0] init;
	wire logic [3:0] weight, btn;
	wire logic [3:0] pulses = {stepperResetPulse, copyPulse, digitPulse, startPulse};
	int failCount = 0, testsRun = 0;
	int cnt[50], ls[5], lc[5];
	bit eos[5];
	logic [31:0] seed = 32'h00000046;
	always #2 clk = ~clk;
	wss_stepper_select #(.HOLD_CYCLES(8)) dut (.clk(clk), .resetn(resetn), .stepperMode(stepperMode),
		.scheduleSelect(scheduleSelect), .programMode(programMode), .countEntry(countEntry),
		.dialedSched(dialedSched), .primary_initiation_input(init[0]), .second_initiation_input(init[1]),
		.third_initiation_input(init[2]), .select_weight_one(weight[0]), .select_weight_two(weight[1]),
		.select_weight_four(weight[2]), .select_weight_eight(weight[3]), .enterBtn(btn[0]),
		.leftDataBtn(btn[1]), .rightDataBtn(btn[2]), .rightSchedBtn(btn[3]), .weldTimeSet(weldTimeSet),
		.weldCurrentSet(weldCurrentSet), .weldMode(weldMode), .seqDone(seqDone), .stepCountWrite(stepCountWrite),
		.stepCountSched(stepCountSched), .stepCountData(stepCountData), .lastWrite(lastWrite),
		.lastWriteStep(lastWriteStep), .lastWriteCount(lastWriteCount), .startPulse(startPulse),
		.startSched(startSched), .startStepper(startStepper), .startDecrements(startDecrements),
		.runActive(runActive), .endOfStepper(endOfStepper), .shownStep(shownStep), .shownCount(shownCount),
		.digitPulse(digitPulse), .digitPlace(digitPlace), .copyPulse(copyPulse),
		.stepperResetPulse(stepperResetPulse));
	wss_panel_model pm (.clk(clk), .init(init), .weight(weight), .btn(btn));
	function automatic int rnd3();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return int'(seed % 3) + 1;
	endfunction
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		testsRun++;
		if (seen !== exp) begin
			failCount++;
			$display("Error %s expected %0d seen %0d", n, exp, seen);
		end
	endtask
	task automatic catchp(input int w, output bit got);
		got = 0;
		for (int i = 0; i < 30 && !got; i++) begin
			@(negedge clk);
			got = pulses[w] === 1'b1;
			plc = digitPlace;
		end
	endtask
	// ----------------------------------------
	// Reference model of the counters
	// ----------------------------------------
	task automatic bump(input int k);
		int b = stepperMode == STEPPER_MULTI ? 10 * k : 0;
		int m = stepperMode == STEPPER_MULTI ? 9 : 49;
		if (lc[k] > 1) lc[k]--;
		else begin
			ls[k]++;
			if (ls[k] > m || cnt[b + ls[k]] == 0) eos[k] = 1;
			else lc[k] = cnt[b + ls[k]];
		end
	endtask
	task automatic show();
		int k = stepperMode == STEPPER_MULTI ? dialedSched / 10 : 0;
		chk("endOfStepper", endOfStepper, eos[k]);
		if (!eos[k]) begin
			chk("shownStep", shownStep, ls[k]);
			chk("shownCount", shownCount, lc[k]);
		end
	endtask
	task automatic start(input int p, input int k, input bit d, input int s);
		bit got;
		bit ok = !(stepperMode != STEPPER_OFF && d && eos[k]) && !(p == 0 && dialedSched > MAX_SCHED &&
			stepperMode != STEPPER_SINGLE && (scheduleSelect == SELECT_INTERNAL || stepperMode == STEPPER_OFF));
		fork
			pm.tap(p);
			catchp(0, got);
		join
		chk("startPulse", got, ok);
		if (got) begin
			chk("startSched", startSched, s);
			chk("startDecrements", startDecrements, d);
			if (stepperMode == STEPPER_MULTI) chk("startStepper", startStepper, k);
			@(negedge clk) seqDone = 1'b1;
			@(negedge clk) seqDone = 1'b0;
			if (d && weldMode && weldTimeSet && weldCurrentSet) bump(k);
			repeat (2) @(negedge clk);
			chk("runActive", runActive, 0);
			if (stepperMode != STEPPER_OFF) show();
		end
	endtask
	task automatic setlast(input int s, input int c, input bit ok);
		int k = stepperMode == STEPPER_MULTI ? dialedSched / 10 : 0;
		@(negedge clk);
		lastWrite = 1'b1;
		lastWriteStep = s[5:0];
		lastWriteCount = c[13:0];
		@(negedge clk) lastWrite = 1'b0;
		if (ok) begin
			ls[k] = s;
			lc[k] = c;
			eos[k] = 0;
		end
		repeat (2) @(negedge clk);
		show();
	endtask
	task automatic gest(input int w, input logic [3:0] pre, input logic [3:0] m, input int len, input bit e);
		bit got;
		fork
			pm.press(pre, m, len);
			catchp(w, got);
		join
		chk("gesturePulse", got, e);
	endtask
	task automatic final_report();
		$display("Comparisons %0d mismatches %0d", testsRun, failCount);
		if (failCount == 0 && testsRun > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		#100000;
		failCount++;
		final_report();
	end
	initial begin
		repeat (6) @(negedge clk);
		resetn = 1'b1;
		for (int s = 0; s < 50; s++) begin
			cnt[s] = rnd3();
			@(negedge clk);
			stepCountWrite = 1'b1;
			stepCountSched = 6'(s);
			stepCountData = 14'(cnt[s]);
		end
		@(negedge clk);
		stepCountSched = 6'h00;
		stepCountData = MAX_COUNT + COUNT_ONE;
		@(negedge clk) stepCountWrite = 1'b0;
		setlast(8, 1, 1);
		setlast(10, 5, 0);
		start(0, 1, 1, 18);
		for (int w = 0; w < 3; w++) begin
			{weldMode, weldTimeSet, weldCurrentSet} = ~(3'h1 << w);
			start(0, 1, 1, 10 + ls[1]);
		end
		{weldMode, weldTimeSet, weldCurrentSet} = 3'h7;
		dialedSched = 6'h28;
		start(0, 4, 1, 40);
		start(1, 1, 1, 10 + ls[1]);
		start(2, 2, 1, 20 + ls[2]);
		dialedSched = 6'h32;
		start(0, 4, 1, 0);
		dialedSched = 6'h28;
		$display("internal select done");
		scheduleSelect = SELECT_EXTERNAL;
		for (int q = 0; q < 4; q++) begin
			pm.lvl(q[1:0], 4'h0);
			start(0, q, 1, 10 * q + ls[q]);
		end
		scheduleSelect = SELECT_BINARY;
		for (int q = 0; q < 5; q++) begin
			pm.lvl(2'h0, q == 0 ? 4'h0 : 4'h1 << (q - 1));
			start(0, q, 1, 10 * q + ls[q]);
		end
		pm.lvl(2'h0, 4'h0);
		scheduleSelect = SELECT_INTERNAL;
		dialedSched = 6'h00;
		setlast(9, 1, 1);
		start(0, 0, 1, 9);
		start(0, 0, 1, 9);
		$display("external and end done");
		for (int m = 0; m < 2; m++) begin
			programMode = m[0];
			gest(3, 4'h1, 4'h6, 6, m[0]);
			gest(2, 4'h1, 4'h8, 6, m[0]);
		end
		ls[0] = 0;
		lc[0] = cnt[0];
		eos[0] = 0;
		show();
		programMode = 1'b0;
		countEntry = 1'b1;
		for (int i = 0; i < 4; i++) begin
			gest(1, 4'h0, i < 2 ? 4'h2 : 4'h4, i % 2 ? 2 : 14, 1);
			chk("digitPlace", plc, 3 - i);
		end
		countEntry = 1'b0;
		$display("panel gestures done");
		stepperMode = STEPPER_SINGLE;
		dialedSched = 6'h21;
		setlast(5, 2, 1);
		start(0, 0, 1, 5);
		start(1, 0, 0, 10);
		start(2, 0, 0, 20);
		scheduleSelect = SELECT_BINARY;
		pm.lvl(2'h0, 4'h4);
		start(1, 0, 0, 30);
		stepperMode = STEPPER_OFF;
		start(0, 0, 0, 33);
		$display("single counter done");
		final_report();
	end
endmodule
